// ===== src/dst_controller.sv
// Status reporting and track formatting for sector, address and track commands
//
// Contract
// RULE_01: Not-ready reads inverse ready, or master reset.
// RULE_02: Refuse disk commands while drive not ready.
// RULE_03: Write-protect bit on writes, cleared on update.
// RULE_04: Record type on read, write fault on write.
// RULE_05: Record-missing flag when target not located.
// RULE_06: CRC bit: ID field if missing, else data.
// RULE_07: Lost data when host misses one byte time.
// RULE_08: Request bit mirrors the request pin.
// RULE_09: Busy set throughout command execution.
// RULE_10: Host picks sector size 128 to 1024.
// RULE_11: Single density standard uses 128-byte sectors.
// RULE_12: Double density standard uses 256-byte sectors.
// RULE_13: Byte F7 becomes two CRC bytes.
// RULE_14: Length code 01 marks 256-byte sectors.
// RULE_15: Side byte is 00 or 01.
// RULE_16: Sector pattern repeats 26 times per track.
// RULE_17: ID gap byte counts are exact.
// RULE_18: Other gaps keep their minimum sizes.
// RULE_19: CRC preset on F8-FE single, F5 double.
// RULE_20: Host keeps F5-FE out of fields.
// RULE_21: Empty data register writes zero, sets lost.
// RULE_22: FC, FE, FB written as address marks.
// RULE_23: Updated bits clear at each command start.
module dst_controller #(
	parameter int BYTE_CYCLES = dst_pkg::BYTE_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic master_reset_in,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata_q,
	// Drive lines
	input wire logic drive_ready,
	input wire logic write_protect,
	input wire logic write_fault,
	input wire logic index_pulse,
	// Disk engine read channel
	input wire dst_pkg::dst_disk_evt_t disk_evt,
	// Write channel
	output dst_pkg::dst_wr_byte_t wr_byte_q,
	output logic write_gate_q,
	// Host handshake
	output logic byte_request_out,
	output logic command_done_irq
);

	// Register state
	dst_pkg::dst_state_t state_q, state_d;
	dst_pkg::dst_cmd_t cmd_q, cmd_d;
	logic [7:0] status_q, status_d;
	logic [7:0] host_byte_register_q, host_byte_register_d;
	logic [7:0] rdata_d;
	logic drq_d;
	logic irq_d;
	logic mfm_q, mfm_d;
	logic index_q;
	dst_pkg::dst_wr_byte_t wr_d;
	logic gate_d;

	// Helpers
	logic tick;
	logic crc_init;
	logic crc_upd;
	logic [7:0] crc_byte;
	logic [15:0] crc_value;
	logic index_rise;
	logic host_wr_data;
	logic host_rd_data;
	logic host_wr_cmd;
	logic [7:0] take_byte;
	logic empty_now;

	// Decode of the write command group, used in several places, and of the mark byte range
	function automatic logic is_write(input dst_pkg::dst_cmd_t c);
		return (c == dst_pkg::DST_CMD_WRITE_SECTOR) || (c == dst_pkg::DST_CMD_WRITE_TRACK);
	endfunction : is_write

	function automatic logic in_mark_range(input logic [7:0] b);
		return (b >= dst_pkg::BYTE_MARK_LO) && (b <= dst_pkg::BYTE_MARK_HI);
	endfunction : in_mark_range

	dst_crc16 u_crc (
		.clk_sys(clk_sys),
		.rst(rst),
		.init(crc_init),
		.update(crc_upd),
		.data(crc_byte),
		.crc_q(crc_value)
	);

	dst_byte_timer #(
		.BYTE_CYCLES(BYTE_CYCLES)
	) u_timer (
		.clk_sys(clk_sys),
		.rst(rst),
		.run(write_gate_q),
		.double_density(mfm_q),
		.tick_q(tick)
	);

	// Bus strobes and drive edges
	assign host_wr_data = reg_write && (reg_addr == dst_pkg::REG_DATA);
	assign host_rd_data = reg_read && (reg_addr == dst_pkg::REG_DATA);
	assign host_wr_cmd = reg_write && (reg_addr == dst_pkg::REG_COMMAND);
	assign index_rise = index_pulse && !index_q;
	// A byte written in the same cycle as the tick is the one taken
	assign empty_now = byte_request_out && !host_wr_data;
	assign take_byte = host_wr_data ? reg_wdata : host_byte_register_q;

	// Command sequencing, status flags and write channel
	always_comb begin
		state_d = state_q;
		cmd_d = cmd_q;
		status_d = status_q;
		host_byte_register_d = host_byte_register_q;
		drq_d = byte_request_out;
		irq_d = command_done_irq;
		mfm_d = mfm_q;
		wr_d = '0;
		gate_d = write_gate_q;
		crc_init = 1'b0;
		crc_upd = 1'b0;
		crc_byte = take_byte;

		// Host side of the data register
		if (host_wr_data) begin
			host_byte_register_d = reg_wdata;
			if (is_write(cmd_q)) begin
				drq_d = 1'b0;
			end
		end
		if (host_rd_data && !is_write(cmd_q)) begin
			drq_d = 1'b0;
		end
		if (reg_write && (reg_addr == dst_pkg::REG_CONFIG) && (state_q == dst_pkg::DST_IDLE)) begin
			mfm_d = reg_wdata[0];
		end
		if (reg_read && (reg_addr == dst_pkg::REG_STATUS)) begin
			irq_d = 1'b0;
		end

		unique case (state_q)
			dst_pkg::DST_IDLE: begin
				if (host_wr_cmd && reg_wdata[2:0] <= 3'h4) begin
					irq_d = 1'b0;
					if (drive_ready) begin // RULE_02
						cmd_d = dst_pkg::dst_cmd_t'(reg_wdata[2:0]);
						status_d = dst_pkg::STATUS_RESET; // RULE_23
						status_d[dst_pkg::ST_BUSY] = 1'b1; // RULE_09
						drq_d = is_write(cmd_d);
						if (is_write(cmd_d) && write_protect) begin
							status_d[dst_pkg::ST_PROTECT] = 1'b1; // RULE_03
							status_d[dst_pkg::ST_BUSY] = 1'b0;
							drq_d = 1'b0;
							irq_d = 1'b1;
						end else if (cmd_d == dst_pkg::DST_CMD_WRITE_TRACK) begin
							state_d = dst_pkg::DST_WAIT_FIRST;
						end else if (cmd_d == dst_pkg::DST_CMD_WRITE_SECTOR) begin
							state_d = dst_pkg::DST_RUN;
							gate_d = 1'b1;
						end else begin
							state_d = dst_pkg::DST_RUN;
						end
					end
				end
			end
			dst_pkg::DST_WAIT_FIRST: begin
				// Writing waits for the first byte, but index ends the try
				if (index_rise && empty_now) begin
					status_d[dst_pkg::ST_LOST] = 1'b1; // RULE_07
					state_d = dst_pkg::DST_IDLE;
				end else if (!empty_now) begin
					state_d = dst_pkg::DST_WAIT_INDEX;
				end
			end
			dst_pkg::DST_WAIT_INDEX: begin
				if (index_rise) begin
					state_d = dst_pkg::DST_RUN;
					gate_d = 1'b1;
				end
			end
			dst_pkg::DST_RUN: begin
				if (cmd_q == dst_pkg::DST_CMD_WRITE_TRACK && index_rise) begin
					state_d = dst_pkg::DST_IDLE;
				end else if (is_write(cmd_q) && tick) begin
					drq_d = 1'b1;
					wr_d.valid = 1'b1;
					if (empty_now) begin
						wr_d.data = dst_pkg::BYTE_FILL; // RULE_21
						status_d[dst_pkg::ST_LOST] = 1'b1; // RULE_21
						crc_byte = dst_pkg::BYTE_FILL;
						crc_upd = 1'b1;
					end else if (cmd_q != dst_pkg::DST_CMD_WRITE_TRACK) begin
						wr_d.data = take_byte;
						crc_upd = 1'b1;
					end else if (take_byte == dst_pkg::BYTE_CRC) begin
						wr_d.data = crc_value[15:8]; // RULE_13
						state_d = dst_pkg::DST_CRC_LO;
					end else if (mfm_q && take_byte == dst_pkg::BYTE_SYNC_A1) begin
						wr_d.data = dst_pkg::BYTE_A1;
						wr_d.mark = 1'b1;
						crc_init = 1'b1; // RULE_19
						crc_byte = dst_pkg::BYTE_A1;
						crc_upd = 1'b1;
					end else if (mfm_q && take_byte == dst_pkg::BYTE_SYNC_C2) begin
						wr_d.data = dst_pkg::BYTE_C2;
						wr_d.mark = 1'b1;
					end else begin
						wr_d.data = take_byte;
						crc_upd = 1'b1;
						// Missing-clock marks in both densities
						wr_d.mark = (take_byte == dst_pkg::BYTE_INDEX_AM)
							|| (take_byte == dst_pkg::BYTE_ID_AM)
							|| (take_byte == dst_pkg::BYTE_DATA_AM); // RULE_22
						if (!mfm_q && in_mark_range(take_byte)) begin
							crc_init = 1'b1; // RULE_19
							wr_d.mark = 1'b1; // RULE_22
						end
					end
				end
				if (is_write(cmd_q) && write_fault) begin
					status_d[dst_pkg::ST_TYPE_FAULT] = 1'b1; // RULE_04
				end
				// Read channel: a byte arriving while the last is unread replaces it and sets lost
				if (!is_write(cmd_q) && disk_evt.byte_valid) begin
					host_byte_register_d = disk_evt.data;
					drq_d = 1'b1; // RULE_08
					if (byte_request_out && !host_rd_data) begin
						status_d[dst_pkg::ST_LOST] = 1'b1; // RULE_07
					end
				end
				if (cmd_q == dst_pkg::DST_CMD_READ_SECTOR && disk_evt.deleted_mark) begin
					status_d[dst_pkg::ST_TYPE_FAULT] = 1'b1; // RULE_04
				end
				if (cmd_q != dst_pkg::DST_CMD_READ_TRACK && cmd_q != dst_pkg::DST_CMD_WRITE_TRACK) begin
					if (disk_evt.not_found) begin
						status_d[dst_pkg::ST_MISSING] = 1'b1; // RULE_05
					end
					if (disk_evt.crc_error) begin
						status_d[dst_pkg::ST_CRC] = 1'b1; // RULE_06
					end
				end
				if (cmd_q != dst_pkg::DST_CMD_WRITE_TRACK && disk_evt.done) begin
					state_d = dst_pkg::DST_IDLE;
				end
			end
			dst_pkg::DST_CRC_LO: begin
				if (tick) begin
					wr_d.valid = 1'b1;
					wr_d.data = crc_value[7:0]; // RULE_13
					state_d = dst_pkg::DST_RUN;
				end
				if (index_rise) begin
					state_d = dst_pkg::DST_IDLE;
				end
			end
			default: begin
				state_d = dst_pkg::DST_IDLE;
			end
		endcase

		// Every way back to idle except master reset ends the command the same way
		if (state_q != dst_pkg::DST_IDLE && state_d == dst_pkg::DST_IDLE) begin
			status_d[dst_pkg::ST_BUSY] = 1'b0; // RULE_09
			drq_d = 1'b0;
			gate_d = 1'b0;
			irq_d = 1'b1;
		end

		// Master reset aborts whatever runs
		if (master_reset_in) begin
			state_d = dst_pkg::DST_IDLE;
			status_d[dst_pkg::ST_BUSY] = 1'b0;
			drq_d = 1'b0;
			gate_d = 1'b0;
			irq_d = 1'b0;
		end
	end

	// Read data, sampled live so not-ready tracks the drive line
	always_comb begin
		rdata_d = 8'h00;
		if (reg_read) begin
			unique case (reg_addr)
				dst_pkg::REG_STATUS: begin
					rdata_d = status_q;
					rdata_d[dst_pkg::ST_NOT_READY] = !drive_ready || master_reset_in; // RULE_01
					rdata_d[dst_pkg::ST_REQUEST] = byte_request_out; // RULE_08
				end
				dst_pkg::REG_COMMAND: rdata_d = {5'h00, cmd_q};
				dst_pkg::REG_DATA: rdata_d = host_byte_register_q;
				dst_pkg::REG_CONFIG: rdata_d = {7'h00, mfm_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// Register everything on the one clock
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= dst_pkg::DST_IDLE;
			cmd_q <= dst_pkg::DST_CMD_READ_SECTOR;
			status_q <= dst_pkg::STATUS_RESET;
			host_byte_register_q <= dst_pkg::BYTE_RESET;
			reg_rdata_q <= 8'h00;
			byte_request_out <= 1'b0;
			command_done_irq <= 1'b0;
			mfm_q <= 1'b0;
			index_q <= 1'b0;
			wr_byte_q <= '0;
			write_gate_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cmd_q <= cmd_d;
			status_q <= status_d;
			host_byte_register_q <= host_byte_register_d;
			reg_rdata_q <= rdata_d;
			byte_request_out <= drq_d;
			command_done_irq <= irq_d;
			mfm_q <= mfm_d;
			index_q <= index_pulse;
			wr_byte_q <= wr_d;
			write_gate_q <= gate_d;
		end
	end

endmodule : dst_controller

// ===== src/dst_pkg.sv
// Shared constants, types and register map of the disk status and track-format block
package dst_pkg;

	// Register byte offsets on the plain register port
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_COMMAND = 4'h4;
	localparam logic [3:0] REG_DATA = 4'h8;
	localparam logic [3:0] REG_CONFIG = 4'hC;

	// Status bit positions
	localparam int ST_NOT_READY = 7;
	localparam int ST_PROTECT = 6;
	localparam int ST_TYPE_FAULT = 5;
	localparam int ST_MISSING = 4;
	localparam int ST_CRC = 3;
	localparam int ST_LOST = 2;
	localparam int ST_REQUEST = 1;
	localparam int ST_BUSY = 0;

	// Reset values
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [15:0] CRC_PRESET = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h1021;

	// Special bytes of the track image
	localparam logic [7:0] BYTE_CRC = 8'hF7;
	localparam logic [7:0] BYTE_SYNC_A1 = 8'hF5;
	localparam logic [7:0] BYTE_SYNC_C2 = 8'hF6;
	localparam logic [7:0] BYTE_MARK_LO = 8'hF8;
	localparam logic [7:0] BYTE_MARK_HI = 8'hFE;
	localparam logic [7:0] BYTE_INDEX_AM = 8'hFC;
	localparam logic [7:0] BYTE_ID_AM = 8'hFE;
	localparam logic [7:0] BYTE_DATA_AM = 8'hFB;
	localparam logic [7:0] BYTE_A1 = 8'hA1;
	localparam logic [7:0] BYTE_C2 = 8'hC2;
	localparam logic [7:0] BYTE_FILL = 8'h00;

	// One byte time: 32 us in single density at 200 MHz
	localparam int CLK_MHZ = 200;
	localparam int BYTE_TIME_US = 32;
	localparam int BYTE_CYCLES = BYTE_TIME_US * CLK_MHZ;

	// Command codes written to the command register
	typedef enum logic [2:0] {
		DST_CMD_READ_SECTOR = 3'h0,
		DST_CMD_WRITE_SECTOR = 3'h1,
		DST_CMD_READ_ADDRESS = 3'h2,
		DST_CMD_READ_TRACK = 3'h3,
		DST_CMD_WRITE_TRACK = 3'h4
	} dst_cmd_t;

	// Execution state, Gray coded along the usual path
	typedef enum logic [2:0] {
		DST_IDLE = 3'b000,
		DST_WAIT_FIRST = 3'b001,
		DST_WAIT_INDEX = 3'b011,
		DST_RUN = 3'b010,
		DST_CRC_LO = 3'b110
	} dst_state_t;

	// Events from the read channel of the disk engine
	typedef struct packed {
		logic byte_valid;
		logic [7:0] data;
		logic deleted_mark;
		logic not_found;
		logic crc_error;
		logic done;
	} dst_disk_evt_t;

	// One byte for the write channel
	typedef struct packed {
		logic valid;
		logic mark;
		logic [7:0] data;
	} dst_wr_byte_t;

endpackage : dst_pkg

// ===== src/dst_crc16.sv
// Bytewise CRC-16 generator used for the track image
module dst_crc16 (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Control
	input wire logic init,
	input wire logic update,
	input wire logic [7:0] data,
	// Result
	output logic [15:0] crc_q
);

	logic [15:0] crc_d;

	// One byte of the polynomial division, msb first
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			if (r[15] ^ b[i]) begin
				r = {r[14:0], 1'b0} ^ dst_pkg::CRC_POLY;
			end else begin
				r = {r[14:0], 1'b0};
			end
		end
		return r;
	endfunction : crc_step

	// Init may come with an update, so the mark byte enters a fresh register
	always_comb begin
		crc_d = crc_q;
		if (init) begin
			crc_d = dst_pkg::CRC_PRESET;
		end
		if (update) begin
			crc_d = crc_step(crc_d, data);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			crc_q <= dst_pkg::CRC_PRESET;
		end else begin
			crc_q <= crc_d;
		end
	end

endmodule : dst_crc16

// ===== src/dst_byte_timer.sv
// Byte-time pacing for the write channel
module dst_byte_timer #(
	parameter int BYTE_CYCLES = dst_pkg::BYTE_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Control
	input wire logic run,
	input wire logic double_density,
	// One pulse per byte time
	output logic tick_q
);

	logic [15:0] count_q;
	logic [15:0] count_d;
	logic tick_d;
	logic [15:0] last;

	// Double density packs bytes twice as fast
	always_comb begin
		last = double_density ? 16'(BYTE_CYCLES / 2 - 1) : 16'(BYTE_CYCLES - 1);
		count_d = count_q;
		tick_d = 1'b0;
		if (!run) begin
			count_d = 16'h0000;
		end else if (count_q >= last) begin
			count_d = 16'h0000;
			tick_d = 1'b1;
		end else begin
			count_d = count_q + 16'h0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			count_q <= 16'h0000;
			tick_q <= 1'b0;
		end else begin
			count_q <= count_d;
			tick_q <= tick_d;
		end
	end

endmodule : dst_byte_timer

// ===== sim/dst_chk.sv
// Port-level concurrent checks for the disk status controller
module dst_chk #(
	parameter int BYTE_CYCLES = 16
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic master_reset_in,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata_q,
	// Drive lines
	input wire logic drive_ready,
	input wire logic write_protect,
	input wire logic write_fault,
	// Write channel and handshake
	input wire dst_pkg::dst_wr_byte_t wr_byte_q,
	input wire logic write_gate_q,
	input wire logic byte_request_out,
	input wire logic command_done_irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic st_rd;
	logic cmd_wr;
	logic [15:0] gap_q;
	logic [15:0] gap_d;
	// Decoded register strobes
	assign st_rd = reg_read && reg_addr == dst_pkg::REG_STATUS;
	assign cmd_wr = reg_write && reg_addr == dst_pkg::REG_COMMAND;
	// Cycles since last written byte, saturating so idle time never wraps
	always_comb begin
		gap_d = gap_q + {15'h0000, gap_q != 16'hFFFF};
		if (wr_byte_q.valid) gap_d = 16'h0000;
	end
	always_ff @(posedge clk_sys) begin
		gap_q <= rst ? 16'hFFFF : gap_d;
	end
	not_ready_a: assert property (st_rd |=> reg_rdata_q[7] == $past(!drive_ready || master_reset_in))
		else $error("not-ready bit wrong");
	cmd_refused_a: assert property (cmd_wr && !drive_ready && !byte_request_out |=>
		!byte_request_out && !write_gate_q) else $error("command ran while not ready");
	protect_stop_a: assert property (cmd_wr && reg_wdata[2:0] == 3'h1 && drive_ready &&
		write_protect && !write_gate_q && !master_reset_in |=> command_done_irq && !byte_request_out)
		else $error("protected write not stopped");
	fault_shown_a: assert property (write_gate_q && write_fault ##1 st_rd |=> reg_rdata_q[5])
		else $error("write fault not shown");
	request_copy_a: assert property (st_rd |=> reg_rdata_q[1] == $past(byte_request_out))
		else $error("request bit differs from pin");
	gate_busy_a: assert property (st_rd && write_gate_q |=> reg_rdata_q[0])
		else $error("busy low while writing");
	reset_abort_a: assert property (master_reset_in |=> !write_gate_q && !byte_request_out &&
		!command_done_irq) else $error("master reset did not abort");
	mark_byte_a: assert property (wr_byte_q.valid && wr_byte_q.mark |->
		wr_byte_q.data >= dst_pkg::BYTE_MARK_LO || wr_byte_q.data inside {8'hA1, 8'hC2})
		else $error("mark on a plain byte");
	byte_pace_a: assert property (wr_byte_q.valid |-> gap_q >= BYTE_CYCLES / 2 - 1)
		else $error("bytes closer than one byte time");
	cover property (cmd_wr && !drive_ready);
	cover property (wr_byte_q.valid && wr_byte_q.mark);
	cover property (st_rd && write_gate_q);
	cover property (wr_byte_q.valid && wr_byte_q.data == dst_pkg::BYTE_A1);
endmodule : dst_chk

bind dst_controller dst_chk #(.BYTE_CYCLES(BYTE_CYCLES)) dst_chk_inst (
	.clk_sys(clk_sys), .rst(rst), .master_reset_in(master_reset_in),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
	.reg_read(reg_read), .reg_rdata_q(reg_rdata_q), .drive_ready(drive_ready),
	.write_protect(write_protect), .write_fault(write_fault), .wr_byte_q(wr_byte_q),
	.write_gate_q(write_gate_q), .byte_request_out(byte_request_out),
	.command_done_irq(command_done_irq)
);

// ===== sim/dst_drive_model.sv
// Stand-in for the drive and its read engine, stepped by the bench
module dst_drive_model (
	// Clock
	input wire logic clk_sys,
	// Drive lines
	output logic drive_ready,
	output logic write_protect,
	output logic write_fault,
	output logic index_pulse,
	// Read channel
	output dst_pkg::dst_disk_evt_t disk_evt
);
	timeunit 1ns;
	timeprecision 1ps;
	// Ready and quiet at time zero
	initial begin
		drive_ready = 1'b1;
		write_protect = 1'b0;
		write_fault = 1'b0;
		index_pulse = 1'b0;
		disk_evt = '0;
	end
	// Line levels change just after an edge
	task automatic lines(input logic r, input logic p, input logic f);
		@(posedge clk_sys);
		drive_ready <= r;
		write_protect <= p;
		write_fault <= f;
	endtask : lines
	// One event cycle after gap idle cycles; idle data inverted so stale bytes never match
	task automatic send(input int gap, input logic v, input logic [7:0] b, input logic [3:0] fl);
		repeat (gap + 1) @(posedge clk_sys);
		disk_evt <= {v, b, fl};
		@(posedge clk_sys);
		disk_evt <= {1'b0, ~b, 4'h0};
	endtask : send
	// Index hole held a few cycles
	task automatic index_mark;
		@(posedge clk_sys);
		index_pulse <= 1'b1;
		repeat (4) @(posedge clk_sys);
		index_pulse <= 1'b0;
	endtask : index_mark
endmodule : dst_drive_model

// ===== sim/test_disk_status_and_track_format.sv
// Self-checking bench for the status and track-format controller
module test_disk_status_and_track_format;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic master_reset_in = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [7:0] reg_rdata_q;
	logic drive_ready, write_protect, write_fault, index_pulse;
	logic write_gate_q, byte_request_out, command_done_irq;
	dst_pkg::dst_disk_evt_t disk_evt;
	dst_pkg::dst_wr_byte_t wr_byte_q;
	int err_total = 0;
	int total_checks = 0;
	int cycles = 0;
	int seed = 1;
	logic rd_seen = 1'b0;
	logic [15:0] exp_q[$];
	logic [8:0] wr_q[$];
	logic [15:0] note;
	logic [8:0] bnote;
	logic [7:0] d;
	logic [15:0] crc;
	// Cut-down images per density: one ID field, length codes 00 and 01, side byte 01
	// Repeat count and ID gap left out to keep the run short
	logic [7:0] img [2][7] = '{
		'{8'hFC, 8'hFE, 8'h00, 8'h01, 8'h01, 8'h00, 8'hF7},
		'{8'hF6, 8'hF5, 8'hFE, 8'h00, 8'h01, 8'h01, 8'hF7}};
	// Bytes as they should reach the write channel
	logic [7:0] outb [2][7] = '{
		'{8'hFC, 8'hFE, 8'h00, 8'h01, 8'h01, 8'h00, 8'hF7},
		'{8'hC2, 8'hA1, 8'hFE, 8'h00, 8'h01, 8'h01, 8'hF7}};
	logic [7:0] gap [2] = '{8'hFF, 8'h4E};
	logic [7:0] flags [3] = '{8'h3C, 8'h18, 8'h00};
	dst_pkg::dst_cmd_t cmds [3] = '{dst_pkg::DST_CMD_READ_SECTOR,
		dst_pkg::DST_CMD_READ_ADDRESS, dst_pkg::DST_CMD_READ_TRACK};

	// Short byte time keeps the run brief
	dst_controller #(.BYTE_CYCLES(16)) dst_controller_inst (
		.clk_sys(clk_sys), .rst(rst), .master_reset_in(master_reset_in),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata_q(reg_rdata_q), .drive_ready(drive_ready),
		.write_protect(write_protect), .write_fault(write_fault), .index_pulse(index_pulse),
		.disk_evt(disk_evt), .wr_byte_q(wr_byte_q), .write_gate_q(write_gate_q),
		.byte_request_out(byte_request_out), .command_done_irq(command_done_irq));
	dst_drive_model dst_drive_model_inst (
		.clk_sys(clk_sys), .drive_ready(drive_ready), .write_protect(write_protect),
		.write_fault(write_fault), .index_pulse(index_pulse), .disk_evt(disk_evt));

	// 200 MHz clock
	always #2.5 clk_sys = ~clk_sys;

	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic finish_test;
		err_total += exp_q.size() + wr_q.size();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : finish_test

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
	endtask : wr

	// Read strobe; expected value and care mask noted for the watcher
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_read <= 1'b1;
		exp_q.push_back({e & m, m});
		@(posedge clk_sys);
		reg_read <= 1'b0;
	endtask : rd

	task automatic wait_req;
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (byte_request_out !== 1'b1 && n < 100);
		check("byte_request_out", {8'h00, byte_request_out}, 9'h001);
	endtask : wait_req

	task automatic wait_wr;
		int n;
		n = 0;
		while (wr_q.size() != 0 && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
	endtask : wait_wr

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		c = c ^ {b, 8'h00};
		for (int i = 0; i < 8; i++) c = c[15] ? (c << 1) ^ dst_pkg::CRC_POLY : c << 1;
		return c;
	endfunction : crc_byte

	// Watcher: oldest note against what appears at the outputs
	always @(posedge clk_sys) begin
		if (rd_seen) begin
			note = exp_q.size() ? exp_q.pop_front() : 'x;
			check("reg_rdata_q", {1'b0, reg_rdata_q & note[7:0]}, {1'b0, note[15:8]});
		end
		if (wr_byte_q.valid === 1'b1) begin
			bnote = wr_q.size() ? wr_q.pop_front() : 'x;
			check("wr_byte_q", {wr_byte_q.mark, wr_byte_q.data}, bnote);
		end
		rd_seen <= reg_read;
	end

	// Hang guard well above the planned run
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			finish_test();
		end
	end

	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		// Idle status, unmapped place, master reset showing in bit 7
		rd(dst_pkg::REG_STATUS, 8'h00, 8'hFF);
		rd(4'h2, 8'h00, 8'hFF);
		master_reset_in <= 1'b1;
		rd(dst_pkg::REG_STATUS, 8'h80, 8'h81);
		master_reset_in <= 1'b0;
		dst_drive_model_inst.lines(1'b0, 1'b0, 1'b0);
		wr(dst_pkg::REG_COMMAND, 8'h00);
		rd(dst_pkg::REG_STATUS, 8'h80, 8'hFF);
		dst_drive_model_inst.lines(1'b1, 1'b0, 1'b0);
		// Each read command; leftover bits must clear at the next start
		for (int i = 0; i < 3; i++) begin
			wr(dst_pkg::REG_COMMAND, {5'h00, cmds[i]});
			rd(dst_pkg::REG_STATUS, 8'h01, 8'hFF);
			d = 8'($random(seed));
			dst_drive_model_inst.send(i * 3, 1'b1, d, 4'h0);
			rd(dst_pkg::REG_STATUS, 8'h03, 8'hFF);
			rd(dst_pkg::REG_DATA, d, 8'hFF);
			if (i == 0) begin
				dst_drive_model_inst.send(0, 1'b1, ~d, 4'h0);
				dst_drive_model_inst.send(0, 1'b1, d, 4'h0);
			end
			dst_drive_model_inst.send(0, 1'b0, d, 4'hE);
			dst_drive_model_inst.send(0, 1'b0, d, 4'h1);
			rd(dst_pkg::REG_STATUS, flags[i], 8'hFD);
		end
		// Protected drive ends a write at once
		dst_drive_model_inst.lines(1'b1, 1'b1, 1'b0);
		wr(dst_pkg::REG_COMMAND, {5'h00, dst_pkg::DST_CMD_WRITE_SECTOR});
		rd(dst_pkg::REG_STATUS, 8'h40, 8'hFD);
		// Sector write with fault; starved byte goes out as zero
		dst_drive_model_inst.lines(1'b1, 1'b0, 1'b0);
		wr(dst_pkg::REG_COMMAND, {5'h00, dst_pkg::DST_CMD_WRITE_SECTOR});
		rd(dst_pkg::REG_STATUS, 8'h01, 8'hFD);
		d = 8'($random(seed));
		wr_q.push_back({1'b0, d});
		wr(dst_pkg::REG_DATA, d);
		dst_drive_model_inst.lines(1'b1, 1'b0, 1'b1);
		rd(dst_pkg::REG_STATUS, 8'h21, 8'hFD);
		wait_wr();
		wr_q.push_back(9'h000);
		wait_wr();
		dst_drive_model_inst.send(0, 1'b0, d, 4'h1);
		dst_drive_model_inst.lines(1'b1, 1'b0, 1'b0);
		rd(dst_pkg::REG_STATUS, 8'h24, 8'hFD);
		// Track images, single then double density; F7 asks for the CRC pair
		for (int m = 0; m < 2; m++) begin
			wr(dst_pkg::REG_CONFIG, 8'(m));
			rd(dst_pkg::REG_CONFIG, 8'(m), 8'hFF);
			wr(dst_pkg::REG_COMMAND, {5'h00, dst_pkg::DST_CMD_WRITE_TRACK});
			wait_req();
			for (int k = 0; k < 7; k++) begin
				// Fill gap after the first byte, held at its 16-byte minimum
				if (k == 1) begin
					repeat (16) begin
						wr_q.push_back({1'b0, gap[m]});
						wait_req();
						wr(dst_pkg::REG_DATA, gap[m]);
					end
				end
				if (k == 1) crc = dst_pkg::CRC_PRESET;
				if (k > 0 && k < 6) crc = crc_byte(crc, outb[m][k]);
				if (k < 6) wr_q.push_back({k < m + 2, outb[m][k]});
				if (k == 6) wr_q.push_back({1'b0, crc[15:8]});
				if (k == 6) wr_q.push_back({1'b0, crc[7:0]});
				if (k > 0) wait_req();
				wr(dst_pkg::REG_DATA, img[m][k]);
				if (k == 0) dst_drive_model_inst.index_mark();
			end
			wr_q.push_back(9'h000);
			wait_wr();
			dst_drive_model_inst.index_mark();
			rd(dst_pkg::REG_STATUS, 8'h04, 8'hFD);
		end
		// The watcher takes the last read one edge later, so let it drain first
		repeat (2) @(posedge clk_sys);
		finish_test();
	end
endmodule : test_disk_status_and_track_format
